/* File: spl_pkg.sv */
// Package: register map, field layout and reset values of the strobed port latch
package spl_pkg;
  localparam int          PORT_W      = 8;
  localparam int          NUM_GROUPS  = 1;
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_MASK    = 12'h008;
  localparam logic [11:0] OFF_LIVE    = 12'h00c;
  localparam logic [11:0] OFF_DATA0   = 12'h010;
  localparam int          CTRL_FALL   = 0;
  localparam int          CTRL_LATCH  = 1;
  localparam int          CTRL_EXTPACE = 2;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
  localparam int          STAT_REQ    = 0;
  localparam int          STAT_OVR    = 1;
  typedef enum logic [1:0] {
    SPL_BASIC   = 2'b00,
    SPL_STROBED = 2'b01,
    SPL_STRB_NI = 2'b10
  } spl_mode_t;
endpackage

/* File: spl_edge_detect.sv */
// Synchroniser and selectable edge detector for the external request line
`timescale 1ns/1ps
module spl_edge_detect (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic reqPin,
  input  wire logic reqEnN,
  input  wire logic fallSel,
  output logic      activeEdge
);
  logic       reqMeta_q, reqSync_q, reqPrev_q;
  logic       enMeta_q, enSync_q;
  logic [1:0] settleCnt_q;

  // The pin's idle level is unknown at reset; no edge counts until the history is filled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      settleCnt_q <= 2'h0;
    end else if (settleCnt_q != 2'h3) begin
      settleCnt_q <= settleCnt_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reqMeta_q <= 1'b0;
      reqSync_q <= 1'b0;
      reqPrev_q <= 1'b0;
      enMeta_q  <= 1'b1;
      enSync_q  <= 1'b1;
    end else begin
      reqMeta_q <= reqPin;
      reqSync_q <= reqMeta_q;
      reqPrev_q <= reqSync_q;
      enMeta_q  <= reqEnN;
      enSync_q  <= enMeta_q;
    end
  end

  always_comb begin
    if (settleCnt_q != 2'h3) begin
      activeEdge = 1'b0;
    end else if (enSync_q) begin
      activeEdge = 1'b0;
    end else if (fallSel) begin
      activeEdge = reqPrev_q & ~reqSync_q;
    end else begin
      activeEdge = ~reqPrev_q & reqSync_q;
    end
  end
endmodule

/* File: spl_port_latch.sv */
// Top: port groups with strobed input latch, request interrupt and APB registers
//
// Overview of operation
// - Each group has three independent eight-bit ports A, B and C.
// - Small variant has one group; large variant four groups.
// - Active edge of request input raises interrupt; rising or falling selectable.
// - After reset the rising edge is the active edge.
// - Request edges count only while the active-low enable is low.
// - With latching on, each active edge captures the input ports.
// - Basic mode without external pacing reads live inputs; strobed modes or pacing read latched inputs.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module spl_port_latch #(
  parameter int NUM_GROUPS = spl_pkg::NUM_GROUPS
) (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic [NUM_GROUPS*8-1:0]       first_port_lines,
  input  wire logic [NUM_GROUPS*8-1:0]       second_port_lines,
  input  wire logic [NUM_GROUPS*8-1:0]       third_port_lines,
  input  wire logic                          extReq,
  input  wire logic                          extReqEnN,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               irq
);
  localparam int PW = NUM_GROUPS * 8;

  ////////////////////////////////////////////////////////////////////////////
  // Port input synchronisers
  logic [PW-1:0] aMeta_q, aSync_q, bMeta_q, bSync_q, cMeta_q, cSync_q;
  logic [PW-1:0] aLat_q, bLat_q, cLat_q;

  // Port lines are asynchronous: two flops each before any logic reads them
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aMeta_q <= '0;
      aSync_q <= '0;
    end else begin
      aMeta_q <= first_port_lines;
      aSync_q <= aMeta_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bMeta_q <= '0;
      bSync_q <= '0;
    end else begin
      bMeta_q <= second_port_lines;
      bSync_q <= bMeta_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cMeta_q <= '0;
      cSync_q <= '0;
    end else begin
      cMeta_q <= third_port_lines;
      cSync_q <= cMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [31:0] ctrl_q, mask_q, status_q;
  logic        activeEdge;
  logic        latchOn;
  logic        wrAcc, rdAcc;
  logic        ctrlWr, maskWr, statusWr;
  spl_pkg::spl_mode_t mode;

  // One word per register; the offset compare is shared by write and read decoders
  function automatic logic regSel(input logic [11:0] a, input logic [11:0] off);
    regSel = (a == off);
  endfunction

  // Data words form a run of aligned addresses, one word per port group
  function automatic logic dataSel(input logic [11:0] a);
    dataSel = (a >= spl_pkg::OFF_DATA0) &&
              (a < spl_pkg::OFF_DATA0 + 12'(NUM_GROUPS * 4)) &&
              (a[1:0] == 2'b00);
  endfunction

  assign wrAcc = psel & penable & pwrite;
  assign rdAcc = psel & penable & ~pwrite;
  // Writes land on both access edges; the same value twice is harmless
  assign ctrlWr   = wrAcc & regSel(paddr, spl_pkg::OFF_CTRL);
  assign maskWr   = wrAcc & regSel(paddr, spl_pkg::OFF_MASK);
  assign statusWr = wrAcc & regSel(paddr, spl_pkg::OFF_STATUS);
  // Mode code 3 has no name of its own and reads as strobed
  assign mode  = spl_pkg::spl_mode_t'(ctrl_q[spl_pkg::CTRL_LATCH +: 2]);
  // Strobed modes, or external request pacing, use the latched buffers
  assign latchOn = (mode != spl_pkg::SPL_BASIC)
                 | ctrl_q[spl_pkg::CTRL_EXTPACE];

  spl_edge_detect uEdge (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .reqPin     (extReq),
    .reqEnN     (extReqEnN),
    .fallSel    (ctrl_q[spl_pkg::CTRL_FALL]),
    .activeEdge (activeEdge)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= spl_pkg::CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl_q <= {28'h0000000, pwdata[3:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_q <= spl_pkg::MASK_RESET;
    end else if (maskWr) begin
      mask_q <= {30'h00000000, pwdata[1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobed input latch
  // Loaded from the synchronised copies so all three ports share one sample instant
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aLat_q <= '0;
      bLat_q <= '0;
      cLat_q <= '0;
    end else if (activeEdge && latchOn) begin
      aLat_q <= aSync_q;
      bLat_q <= bSync_q;
      cLat_q <= cSync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over write-one-to-clear
  logic        ovrEv;
  logic [31:0] clrMask;

  // Overrun marks an edge that came before software cleared the previous one
  assign ovrEv   = activeEdge & status_q[spl_pkg::STAT_REQ];
  assign clrMask = statusWr ? pwdata : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_q <= 32'h0000_0000;
    end else begin
      status_q[spl_pkg::STAT_REQ] <= activeEdge
        | (status_q[spl_pkg::STAT_REQ] & ~clrMask[spl_pkg::STAT_REQ]);
      status_q[spl_pkg::STAT_OVR] <= ovrEv
        | (status_q[spl_pkg::STAT_OVR] & ~clrMask[spl_pkg::STAT_OVR]);
      status_q[31:2] <= 30'h00000000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path; one wait state so pready is registered
  function automatic logic [31:0] portWord(input logic [PW-1:0] a, input logic [PW-1:0] b,
                                           input logic [PW-1:0] c, input int g);
    portWord = {8'h00, c[g*8 +: 8], b[g*8 +: 8], a[g*8 +: 8]};
  endfunction

  logic [31:0] rdVal;
  logic        rdHit;
  int          grp;

  always_comb begin
    rdVal = 32'h0000_0000;
    rdHit = 1'b1;
    grp   = 0;
    if (regSel(paddr, spl_pkg::OFF_CTRL)) begin
      rdVal = ctrl_q;
    end else if (regSel(paddr, spl_pkg::OFF_STATUS)) begin
      rdVal = status_q;
    end else if (regSel(paddr, spl_pkg::OFF_MASK)) begin
      rdVal = mask_q;
    end else if (regSel(paddr, spl_pkg::OFF_LIVE)) begin
      rdVal = {30'h00000000, latchOn, activeEdge};
    end else if (dataSel(paddr)) begin
      grp = int'((paddr - spl_pkg::OFF_DATA0) >> 2);
      if (latchOn) begin
        rdVal = portWord(aLat_q, bLat_q, cLat_q, grp);
      end else begin
        rdVal = portWord(aSync_q, bSync_q, cSync_q, grp);
      end
    end else begin
      rdHit = 1'b0;
    end
  end

  // Unmapped addresses answer with an error; writes there change nothing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rdHit;
    end
  end

  // Read data stands only in the pready cycle and is zero otherwise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (rdAcc && !pready) ? rdVal : 32'h0000_0000;
    end
  end
endmodule

/* File: spl_monitor.sv */
// Checker: bus timing, map and interrupt relations of the strobed port latch
`timescale 1ns/1ps
module spl_monitor #(
  parameter int NUM_GROUPS = 1
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  rdy_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  rdy_timing_a: assert property ($rose(psel && penable) |=> pready)
    else $error("pready late after access phase");
  rdy_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  rd_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero while idle");
  map_err_a: assert property (pready && paddr[1:0] == 2'h0
    |-> pslverr == (paddr >= 16 + 4 * NUM_GROUPS)) else $error("pslverr wrong for address");
  irq_fall_a: assert property ($fell(irq) |-> $past(psel && pwrite, 2))
    else $error("irq dropped without a write");
  rst_quiet_a: assert property ($fell(sys_rst) |-> !pready && !irq)
    else $error("outputs active after reset");
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property (pready && !pwrite);
endmodule
bind spl_port_latch spl_monitor #(.NUM_GROUPS(NUM_GROUPS)) mon (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

/* File: spl_ext_model.sv */
// Model of the external equipment on the port and request lines
`timescale 1ns/1ps
module spl_ext_model (
  input wire logic   sys_clk,
  output logic [7:0] portA,
  output logic [7:0] portB,
  output logic [7:0] portC,
  output logic       req,
  output logic       reqEnN
);
  initial begin
    {portA, portB, portC, req, reqEnN} = '0;
  end
  // Data and enable settle ahead of the request move so all synchronisers agree
  task drive(input logic [23:0] d, input logic lvl, input logic enN);
    @(posedge sys_clk);
    {portC, portB, portA} <= d;
    reqEnN <= enN;
    repeat (3) @(posedge sys_clk);
    req <= lvl;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

/* File: spl_port_latch_tb.sv */
// Self-checking bench for the strobed port latch
`timescale 1ns/1ps
module spl_port_latch_tb;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, extReq, extReqEnN;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  portA, portB, portC;
  logic [31:0] expQ[$];
  logic        errQ[$];
  int          nMismatch, checksDone;
  logic [23:0] d1, d2;
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;
  spl_ext_model ext (.sys_clk(sys_clk), .portA(portA), .portB(portB), .portC(portC),
    .req(extReq), .reqEnN(extReqEnN));
  spl_port_latch #(.NUM_GROUPS(1)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .first_port_lines(portA), .second_port_lines(portB), .third_port_lines(portC),
    .extReq(extReq), .extReqEnN(extReqEnN), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task complete_run;
    $display("Counts: %0d checks, %0d mismatches", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
           input logic err);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    errQ.push_back(err);
    if (!w) expQ.push_back(e);
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      nMismatch++;
      complete_run;
    end
  endtask
  always @(posedge sys_clk) begin
    if (pready === 1'b1) begin
      check("pslverr", {31'h0, errQ.pop_front()}, {31'h0, pslverr});
      if (!pwrite) check("prdata", expQ.pop_front(), prdata);
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sys_rst} = {47'h0, 1'b1};
    void'($urandom(58));
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(0, spl_pkg::OFF_CTRL, 0, spl_pkg::CTRL_RESET, 0);
    apb(0, spl_pkg::OFF_MASK, 0, spl_pkg::MASK_RESET, 0);
    for (int m = 0; m < 4; m++) begin
      d1 = 24'($urandom());
      d2 = 24'($urandom());
      apb(1, spl_pkg::OFF_CTRL, 32'(m << 1), 0, 0);
      ext.drive(d2, 1'b0, 1'b0);
      ext.drive(d1, 1'b1, 1'b0);
      ext.drive(d2, 1'b1, 1'b0);
      apb(0, spl_pkg::OFF_DATA0, 0, {8'h00, (m == 0) ? d2 : d1}, 0);
    end
    apb(0, spl_pkg::OFF_STATUS, 0, 32'h3, 0);
    apb(1, spl_pkg::OFF_MASK, 32'h1, 0, 0);
    repeat (3) @(posedge sys_clk);
    check("irq", 32'h1, {31'h0, irq});
    apb(1, spl_pkg::OFF_MASK, 32'h0, 0, 0);
    repeat (3) @(posedge sys_clk);
    check("irq", 32'h0, {31'h0, irq});
    apb(1, spl_pkg::OFF_MASK, 32'h1, 0, 0);
    apb(1, spl_pkg::OFF_STATUS, 32'h3, 0, 0);
    repeat (3) @(posedge sys_clk);
    check("irq", 32'h0, {31'h0, irq});
    d2 = 24'($urandom());
    ext.drive(d2, 1'b0, 1'b1);
    ext.drive(d2, 1'b1, 1'b1);
    apb(0, spl_pkg::OFF_STATUS, 0, 32'h0, 0);
    apb(0, spl_pkg::OFF_DATA0, 0, {8'h00, d1}, 0);
    apb(1, spl_pkg::OFF_CTRL, 32'h3, 0, 0);
    ext.drive(d2, 1'b0, 1'b0);
    ext.drive(d1, 1'b1, 1'b0);
    apb(0, spl_pkg::OFF_DATA0, 0, {8'h00, d2}, 0);
    apb(0, spl_pkg::OFF_LIVE, 0, 32'h2, 0);
    apb(0, 12'h014, 0, 32'h0, 1);
    apb(1, 12'h020, 32'h1, 0, 1);
    complete_run;
  end
endmodule
